//--- ffoc_pkg.sv
// How it works
// - pin high after reset release selects standard
// - pin low after reset release selects fall-through
// - standard timing drives empty and full flags
// - standard timing presents words only on read
// - fall-through drives the same not-empty and not-full flags as standard
// - first word falls through without read
// - host holds timing pin static afterwards
// - four offset registers, two per fifo
// - flag selects at release load presets
// - host releases both resets for fifo2 presets
// - fs0 fs1 low selects parallel, fs2 parity
// - host keeps fs0 fs1 low after parallel
// - first four fifo1 writes load offsets
// - non-interspersed takes contiguous low bits
// - interspersed parity skips data bit 8
// - highest used bit is offset msb
// - host programs offsets within legal range
// - after four loads raise port c ready
// - fs pattern low-high-low selects serial loading
// - interspersed parity forbids serial loading
// - flag selects behave same in both timings
// - partial reset keeps offsets, method, timing
// - fifo2 reset release alone clears fifo2 offsets
package ffoc_pkg;
	localparam int         OFS_W     = 13;
	localparam int         BUS_W     = 36;
	localparam int         PAR_BIT   = 8;
	localparam int         LOAD_CNT  = 4;
	localparam logic [2:0] FS_P64    = 3'h7;
	localparam logic [2:0] FS_P16    = 3'h6;
	localparam logic [2:0] FS_P8     = 3'h5;
	localparam logic [2:0] FS_P256   = 3'h3;
	localparam logic [2:0] FS_P1024  = 3'h1;
	localparam logic [2:0] FS_SERIAL = 3'h2;
	localparam logic [2:0] FS_PAR_NI = 3'h4;
	localparam logic [2:0] FS_PAR_IP = 3'h0;
	localparam logic [12:0] OFS_64   = 13'h0040;
	localparam logic [12:0] OFS_16   = 13'h0010;
	localparam logic [12:0] OFS_8    = 13'h0008;
	localparam logic [12:0] OFS_256  = 13'h0100;
	localparam logic [12:0] OFS_1024 = 13'h0400;
	localparam logic [12:0] OFS_RST  = 13'h0000;
	typedef enum logic [1:0] {
		FFOC_M_PRESET,
		FFOC_M_PARALLEL,
		FFOC_M_SERIAL
	} ffoc_method_t;
endpackage

//--- ffoc_if.sv
`timescale 1ns/1ps
interface ffoc_if;
	logic              fifo1_full_reset_n;
	logic              fifo2_full_reset_n;
	logic              part_reset1_n;
	logic              part_reset2_n;
	logic              endian_timing_select;
	logic              flag_sel0_serial_in;
	logic              flag_sel1_serial_enable_n;
	logic              flag_sel2_parity_choice;
	logic              port_a_write;
	logic [35:0]       wide_port_bus;
	modport device (
		input fifo1_full_reset_n, fifo2_full_reset_n, part_reset1_n,
		      part_reset2_n, endian_timing_select, flag_sel0_serial_in,
		      flag_sel1_serial_enable_n, flag_sel2_parity_choice,
		      port_a_write, wide_port_bus
	);
	modport host (
		output fifo1_full_reset_n, fifo2_full_reset_n, part_reset1_n,
		       part_reset2_n, endian_timing_select, flag_sel0_serial_in,
		       flag_sel1_serial_enable_n, flag_sel2_parity_choice,
		       port_a_write, wide_port_bus
	);
endinterface

//--- ffoc_device.sv
`timescale 1ns/1ps
module ffoc_device #(
	parameter int OFS_WIDTH = 13
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// link
	ffoc_if.device           lnk,
	// fifo state from the storage core
	input  wire logic        fifo1_empty_i,
	input  wire logic        fifo1_full_i,
	input  wire logic        fifo2_empty_i,
	input  wire logic        fifo2_full_i,
	// configuration out
	output logic [12:0]      fifo1_almost_empty_offset_o,
	output logic [12:0]      fifo1_almost_full_offset_o,
	output logic [12:0]      fifo2_almost_empty_offset_o,
	output logic [12:0]      fifo2_almost_full_offset_o,
	output logic             fifo1_fall_through_o,
	output logic             fifo2_fall_through_o,
	output logic             interspersed_parity_mode_o,
	output logic             serial_load_mode_o,
	output logic             mem_write_o,
	output logic             fifo1_write_ready_o,
	output logic             port_c_input_ready_o,
	// flags
	output logic             port_b_flag_o,
	output logic             port_a_flag_o,
	output logic             port_a_full_flag_o,
	output logic             port_c_full_flag_o
);
	// the grab mask and the 13-bit outputs serve only these widths
	if (OFS_WIDTH < 11 || OFS_WIDTH > 13) begin : g_width_check
		$error("offset width must be 11 to 13");
	end

	// ****************************************
	// configuration state
	// ****************************************
	logic [12:0]          x1, y1, x2, y2;
	logic [12:0]          next_x1, next_y1, next_x2, next_y2;
	logic                 ft1, ft2, next_ft1, next_ft2;
	logic                 tpend1, tpend2, next_tpend1, next_tpend2;
	logic                 ip, next_ip;
	ffoc_pkg::ffoc_method_t meth, next_meth;
	logic [2:0]           lcnt, next_lcnt;
	logic                 m1_q, m2_q;
	logic                 rdy1, rdy2, next_rdy1, next_rdy2;
	logic                 mw, next_mw;
	logic                 ser, next_ser;
	logic [2:0]           fs;
	logic [12:0]          pval, preset;
	logic                 rel1, rel2;

	function automatic logic [12:0] fs_preset(input logic [2:0] f);
		case (f)
			ffoc_pkg::FS_P64:   fs_preset = ffoc_pkg::OFS_64;
			ffoc_pkg::FS_P16:   fs_preset = ffoc_pkg::OFS_16;
			ffoc_pkg::FS_P8:    fs_preset = ffoc_pkg::OFS_8;
			ffoc_pkg::FS_P256:  fs_preset = ffoc_pkg::OFS_256;
			ffoc_pkg::FS_P1024: fs_preset = ffoc_pkg::OFS_1024;
			default:            fs_preset = ffoc_pkg::OFS_RST;
		endcase
	endfunction

	// width-masked offset from the wide bus
	function automatic logic [12:0] grab(input logic [35:0] d,
	                                      input logic ipm);
		logic [12:0] s;
		logic [12:0] m;
		s = ipm ? {d[13:9], d[7:0]} : d[12:0];
		m = 13'h1fff >> (13 - OFS_WIDTH);
		grab = s & m;
	endfunction

	assign fs     = {lnk.flag_sel2_parity_choice,
	                 lnk.flag_sel1_serial_enable_n,
	                 lnk.flag_sel0_serial_in};
	assign rel1   = lnk.fifo1_full_reset_n & ~m1_q;
	assign rel2   = lnk.fifo2_full_reset_n & ~m2_q;
	assign preset = fs_preset(fs);
	assign pval   = grab(lnk.wide_port_bus, ip);

	always_comb begin
		next_x1 = x1;
		next_y1 = y1;
		next_x2 = x2;
		next_y2 = y2;
		next_ft1 = ft1;
		next_ft2 = ft2;
		next_tpend1 = tpend1;
		next_tpend2 = tpend2;
		next_ip = ip;
		next_meth = meth;
		next_lcnt = lcnt;
		next_rdy1 = rdy1;
		next_rdy2 = rdy2;
		next_mw = 1'b0;
		// timing mode: pin level at second edge after release
		if (tpend1) begin
			next_ft1 = ~lnk.endian_timing_select;
			next_tpend1 = 1'b0;
		end
		if (tpend2) begin
			next_ft2 = ~lnk.endian_timing_select;
			next_tpend2 = 1'b0;
		end
		if (rel2) begin
			next_x2 = ffoc_pkg::OFS_RST;
			next_y2 = ffoc_pkg::OFS_RST;
			next_tpend2 = 1'b1;
			next_rdy2 = 1'b0;
		end
		if (rel1) begin
			next_tpend1 = 1'b1;
			next_rdy1 = 1'b0;
			next_x1 = preset;
			next_y1 = preset;
			next_meth = ffoc_pkg::FFOC_M_PRESET;
			next_ip = 1'b0;
			next_lcnt = 3'h0;
			if (fs == ffoc_pkg::FS_SERIAL && rel2) begin
				next_meth = ffoc_pkg::FFOC_M_SERIAL;
			end else if ((fs == ffoc_pkg::FS_PAR_NI ||
			              fs == ffoc_pkg::FS_PAR_IP) && rel2) begin
				next_meth = ffoc_pkg::FFOC_M_PARALLEL;
				next_ip = ~fs[2];
			end else begin
				next_rdy1 = 1'b1;
				next_rdy2 = 1'b1;
			end
			if (rel2) begin
				next_x2 = preset;
				next_y2 = preset;
			end
		end else if (rel2) begin
			next_rdy2 = 1'b1;
		end else if (meth == ffoc_pkg::FFOC_M_PARALLEL &&
		             lnk.port_a_write) begin
			if (lcnt < 3'(ffoc_pkg::LOAD_CNT)) begin
				case (lcnt)
					3'h0: next_y1 = pval;
					3'h1: next_x1 = pval;
					3'h2: next_y2 = pval;
					3'h3: next_x2 = pval;
					default: next_x2 = x2;
				endcase
				next_lcnt = lcnt + 3'h1;
				next_rdy1 = 1'b1;
				if (lcnt == 3'h3)
					next_rdy2 = 1'b1;
			end else begin
				next_mw = 1'b1;
			end
		end else if (lnk.port_a_write && rdy1) begin
			next_mw = 1'b1;
		end
		next_ser = (next_meth == ffoc_pkg::FFOC_M_SERIAL);
	end

	// partial reset touches nothing here: it only resets pointers
	// in the storage core, so the settings survive by design.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			x1 <= ffoc_pkg::OFS_RST;
			y1 <= ffoc_pkg::OFS_RST;
			x2 <= ffoc_pkg::OFS_RST;
			y2 <= ffoc_pkg::OFS_RST;
			ft1 <= 1'b0;
			ft2 <= 1'b0;
			tpend1 <= 1'b0;
			tpend2 <= 1'b0;
			ip <= 1'b0;
			meth <= ffoc_pkg::FFOC_M_PRESET;
			lcnt <= 3'h0;
			m1_q <= 1'b0;
			m2_q <= 1'b0;
			rdy1 <= 1'b0;
			rdy2 <= 1'b0;
			mw <= 1'b0;
			ser <= 1'b0;
		end else begin
			x1 <= next_x1;
			y1 <= next_y1;
			x2 <= next_x2;
			y2 <= next_y2;
			ft1 <= next_ft1;
			ft2 <= next_ft2;
			tpend1 <= next_tpend1;
			tpend2 <= next_tpend2;
			ip <= next_ip;
			meth <= next_meth;
			lcnt <= next_lcnt;
			m1_q <= lnk.fifo1_full_reset_n;
			m2_q <= lnk.fifo2_full_reset_n;
			rdy1 <= next_rdy1;
			rdy2 <= next_rdy2;
			mw <= next_mw;
			ser <= next_ser;
		end
	end

	// ****************************************
	// flags
	// ****************************************
	logic pb, pa, pfa, pfc;
	logic next_pb, next_pa, next_pfa, next_pfc;

	always_comb begin
		// both timings: not-empty / not-full, full flags gated by ready
		next_pb  = ~fifo1_empty_i;
		next_pa  = ~fifo2_empty_i;
		next_pfa = rdy1 & ~fifo1_full_i;
		next_pfc = rdy2 & ~fifo2_full_i;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pb <= 1'b0;
			pa <= 1'b0;
			pfa <= 1'b0;
			pfc <= 1'b0;
		end else begin
			pb <= next_pb;
			pa <= next_pa;
			pfa <= next_pfa;
			pfc <= next_pfc;
		end
	end

	assign fifo1_almost_empty_offset_o = x1;
	assign fifo1_almost_full_offset_o  = y1;
	assign fifo2_almost_empty_offset_o = x2;
	assign fifo2_almost_full_offset_o  = y2;
	assign fifo1_fall_through_o        = ft1;
	assign fifo2_fall_through_o        = ft2;
	assign interspersed_parity_mode_o  = ip;
	assign serial_load_mode_o          = ser;
	assign mem_write_o                 = mw;
	assign fifo1_write_ready_o         = rdy1;
	assign port_c_input_ready_o        = rdy2;
	assign port_b_flag_o               = pb;
	assign port_a_flag_o               = pa;
	assign port_a_full_flag_o          = pfa;
	assign port_c_full_flag_o          = pfc;
endmodule

//--- ffoc_host.sv
`timescale 1ns/1ps
module ffoc_host (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// link
	ffoc_if.host             lnk,
	// user commands
	input  wire logic        start_i,
	input  wire logic        fall_through_i,
	input  wire logic [2:0]  flag_sel_i,
	input  wire logic        write_i,
	input  wire logic [35:0] write_data_i,
	output logic             busy_o
);
	typedef enum logic [1:0] {
		FFOC_H_IDLE,
		FFOC_H_RESET,
		FFOC_H_RUN
	} ffoc_hstate_t;

	// ****************************************
	// reset sequencer
	// ****************************************
	ffoc_hstate_t st, next_st;
	logic [2:0]   cnt, next_cnt;
	logic [2:0]   fsel, next_fsel;
	logic         ftq, next_ftq;
	logic         wr, next_wr;
	logic [35:0]  wd, next_wd;

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_fsel = fsel;
		next_ftq = ftq;
		next_wr = 1'b0;
		next_wd = wd;
		case (st)
			FFOC_H_IDLE, FFOC_H_RUN: begin
				if (start_i) begin
					next_st = FFOC_H_RESET;
					next_cnt = 3'h0;
					next_fsel = flag_sel_i;
					next_ftq = fall_through_i;
				end else if (st == FFOC_H_RUN && write_i) begin
					next_wr = 1'b1;
					next_wd = write_data_i;
				end
			end
			FFOC_H_RESET: begin
				next_cnt = cnt + 3'h1;
				if (cnt == 3'h4)
					next_st = FFOC_H_RUN;
			end
			default: next_st = FFOC_H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= FFOC_H_IDLE;
			cnt <= 3'h0;
			fsel <= 3'h7;
			ftq <= 1'b0;
			wr <= 1'b0;
			wd <= 36'h0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			fsel <= next_fsel;
			ftq <= next_ftq;
			wr <= next_wr;
			wd <= next_wd;
		end
	end

	// both resets released together so fifo2 gets the same set-up
	assign lnk.fifo1_full_reset_n = (st != FFOC_H_RESET);
	assign lnk.fifo2_full_reset_n = (st != FFOC_H_RESET);
	assign lnk.part_reset1_n = 1'b1;
	assign lnk.part_reset2_n = 1'b1;
	// selects held for the whole run: timing and parallel mode
	assign lnk.endian_timing_select = ~ftq;
	assign lnk.flag_sel0_serial_in = fsel[0];
	assign lnk.flag_sel1_serial_enable_n = fsel[1];
	assign lnk.flag_sel2_parity_choice = fsel[2];
	assign lnk.port_a_write = wr;
	assign lnk.wide_port_bus = wd;
	assign busy_o = (st == FFOC_H_RESET);
endmodule

//--- ffoc_properties.sv
`timescale 1ns/1ps
module ffoc_properties (
	// clock, reset and link
	input wire logic        ref_clk_i,
	input wire logic        reset_n_i,
	input wire logic        fifo1_full_reset_n,
	input wire logic        fifo2_full_reset_n,
	input wire logic        endian_timing_select,
	input wire logic        flag_sel0_serial_in,
	input wire logic        flag_sel1_serial_enable_n,
	input wire logic        flag_sel2_parity_choice,
	input wire logic        port_a_write,
	// device results
	input wire logic [12:0] fifo1_almost_empty_offset_o,
	input wire logic [12:0] fifo1_almost_full_offset_o,
	input wire logic [12:0] fifo2_almost_empty_offset_o,
	input wire logic [12:0] fifo2_almost_full_offset_o,
	input wire logic        fifo1_fall_through_o,
	input wire logic        interspersed_parity_mode_o,
	input wire logic        serial_load_mode_o,
	input wire logic        mem_write_o,
	input wire logic        port_c_input_ready_o
);
	// ****
	// helpers
	// ****
	logic [2:0]  fs;
	logic [51:0] ofs;
	logic        rel;
	logic [3:0]  settle, next_settle;
	logic [2:0]  wcnt, next_wcnt;
	logic        par, next_par;
	logic        prev1;
	assign fs = {flag_sel2_parity_choice, flag_sel1_serial_enable_n,
		flag_sel0_serial_in};
	assign ofs = {fifo1_almost_empty_offset_o, fifo1_almost_full_offset_o,
		fifo2_almost_empty_offset_o, fifo2_almost_full_offset_o};
	assign rel = fifo1_full_reset_n & ~prev1;
	always_comb begin
		next_settle = (settle == 4'hf) ? settle : settle + 4'h1;
		next_par = rel ? (fs[1:0] == 2'h0) : par;
		next_wcnt = wcnt;
		if (rel)
			next_wcnt = 3'h0;
		else if (port_a_write && wcnt != 3'h7)
			next_wcnt = wcnt + 3'h1;
	end
	// prev1 starts high so the reset release is not taken for a load
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			settle <= 4'h0;
			par    <= 1'b0;
			wcnt   <= 3'h0;
			prev1  <= 1'b1;
		end else begin
			settle <= next_settle;
			par    <= next_par;
			wcnt   <= next_wcnt;
			prev1  <= fifo1_full_reset_n;
		end
	end
	// ****
	// properties
	// ****
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_rel;
		settle == 4'hf ##0 $rose(fifo1_full_reset_n)
			##0 $rose(fifo2_full_reset_n);
	endsequence
	chk_preset_sixtyfour: assert property (s_rel ##0 fs == 3'h7
		|-> ##2 ofs == {4{13'h0040}}) else $error("preset 64 not loaded");
	chk_preset_largest: assert property (s_rel ##0 fs == 3'h1
		|-> ##2 ofs == {4{13'h0400}}) else $error("preset 1024 not loaded");
	chk_serial_select: assert property (s_rel ##0 fs == 3'h2
		|-> ##2 serial_load_mode_o && !interspersed_parity_mode_o)
		else $error("serial load not selected");
	chk_parity_select: assert property (s_rel ##0 fs == 3'h0
		|-> ##2 interspersed_parity_mode_o && !serial_load_mode_o)
		else $error("interspersed parity not selected");
	chk_ip_no_serial: assert property (interspersed_parity_mode_o
		|-> !serial_load_mode_o) else $error("serial offered in interspersed_parity_mode");
	chk_timing_select: assert property (s_rel
		|-> ##3 fifo1_fall_through_o == !endian_timing_select)
		else $error("timing mode wrong");
	chk_ready_early: assert property (par && settle == 4'hf && wcnt < 3'h4
		|-> !port_c_input_ready_o) else $error("ready before four loads");
	chk_ready_rises: assert property (par && wcnt == 3'h3 && port_a_write
		|-> ##[1:3] port_c_input_ready_o) else $error("ready not raised");
	chk_load_no_mem: assert property (mem_write_o
		|-> !par || wcnt > 3'h4) else $error("offset load hit memory");
	chk_fifth_to_mem: assert property (par && wcnt == 3'h4 && port_a_write
		|-> ##[1:2] mem_write_o) else $error("fifth write not stored");
	chk_offset_hold: assert property (settle == 4'hf && fifo1_full_reset_n
		&& $past(fifo1_full_reset_n) && !port_a_write && !$past(port_a_write)
		|=> $stable(ofs)) else $error("offsets changed without cause");
endmodule

//--- fifo_flag_offset_mode_config_tb.sv
`timescale 1ns/1ps
module fifo_flag_offset_mode_config_tb;
	// ****
	// signals
	// ****
	logic        ref_clk_i, reset_n_i, start_i, fall_through_i, write_i;
	logic [2:0]  flag_sel_i;
	logic [35:0] write_data_i;
	logic        busy_o;
	logic [3:0]  core, core_prev;
	wire  [3:0]  flags;
	logic [12:0] fifo1_almost_empty_offset_o, fifo1_almost_full_offset_o;
	logic [12:0] fifo2_almost_empty_offset_o, fifo2_almost_full_offset_o;
	logic        fifo1_fall_through_o, fifo2_fall_through_o;
	logic        interspersed_parity_mode_o, serial_load_mode_o;
	logic        mem_write_o, fifo1_write_ready_o, port_c_input_ready_o;
	logic [31:0] seed;
	int          bad_count, checks, cycles, mem_writes;
	int          exp_ofs[4];
	logic [2:0]  presets[5] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h1};
	ffoc_if lnk_if();
	ffoc_host ffoc_host_i (.ref_clk_i, .reset_n_i, .lnk(lnk_if), .start_i,
		.fall_through_i, .flag_sel_i, .write_i, .write_data_i, .busy_o);
	ffoc_device #(.OFS_WIDTH(13)) ffoc_device_i (.ref_clk_i, .reset_n_i,
		.lnk(lnk_if), .fifo1_empty_i(core[0]), .fifo1_full_i(core[1]),
		.fifo2_empty_i(core[2]), .fifo2_full_i(core[3]),
		.fifo1_almost_empty_offset_o, .fifo1_almost_full_offset_o,
		.fifo2_almost_empty_offset_o, .fifo2_almost_full_offset_o,
		.fifo1_fall_through_o, .fifo2_fall_through_o,
		.interspersed_parity_mode_o, .serial_load_mode_o, .mem_write_o,
		.fifo1_write_ready_o, .port_c_input_ready_o,
		.port_b_flag_o(flags[0]), .port_a_flag_o(flags[1]),
		.port_a_full_flag_o(flags[2]), .port_c_full_flag_o(flags[3]));
	ffoc_properties ffoc_properties_i (.ref_clk_i, .reset_n_i,
		.fifo1_full_reset_n(lnk_if.fifo1_full_reset_n),
		.fifo2_full_reset_n(lnk_if.fifo2_full_reset_n),
		.endian_timing_select(lnk_if.endian_timing_select),
		.flag_sel0_serial_in(lnk_if.flag_sel0_serial_in),
		.flag_sel1_serial_enable_n(lnk_if.flag_sel1_serial_enable_n),
		.flag_sel2_parity_choice(lnk_if.flag_sel2_parity_choice),
		.port_a_write(lnk_if.port_a_write), .fifo1_almost_empty_offset_o,
		.fifo1_almost_full_offset_o, .fifo2_almost_empty_offset_o,
		.fifo2_almost_full_offset_o, .fifo1_fall_through_o,
		.interspersed_parity_mode_o, .serial_load_mode_o, .mem_write_o,
		.port_c_input_ready_o);
	// ****
	// helpers
	// ****
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic int preset_val(input logic [2:0] fs);
		case (fs)
			3'h7: return 64;
			3'h6: return 16;
			3'h5: return 8;
			3'h3: return 256;
			default: return 1024;
		endcase
	endfunction
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
		end
	endtask
	task automatic cmp_ofs();
		chk("x1", exp_ofs[0], fifo1_almost_empty_offset_o);
		chk("y1", exp_ofs[1], fifo1_almost_full_offset_o);
		chk("x2", exp_ofs[2], fifo2_almost_empty_offset_o);
		chk("y2", exp_ofs[3], fifo2_almost_full_offset_o);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// host raises busy on the same edge that samples start; still wait at least three
	task automatic setup(input logic [2:0] fs, input logic ft);
		int n;
		@(posedge ref_clk_i);
		flag_sel_i <= fs;
		fall_through_i <= ft;
		start_i <= 1'b1;
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while ((busy_o !== 1'b0 || n < 3) && n < 40);
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("fifo1 timing", ft, fifo1_fall_through_o);
		chk("fifo2 timing", ft, fifo2_fall_through_o);
	endtask
	task automatic wr(input logic [35:0] d);
		@(posedge ref_clk_i);
		write_data_i <= d;
		write_i <= 1'b1;
		@(posedge ref_clk_i);
		write_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	task automatic parallel_test(input logic ip);
		int          order[$] = {1, 0, 3, 2};
		int          mw;
		logic [12:0] v;
		logic [35:0] d;
		setup(ip ? 3'h0 : 3'h4, ip);
		// parallel selection loads no preset, so all four start cleared
		exp_ofs = '{4{0}};
		chk("interspersed_parity_mode", ip, interspersed_parity_mode_o);
		chk("serial mode", 0, serial_load_mode_o);
		mw = mem_writes;
		for (int k = 0; k < 6; k++) begin
			v = 13'((seed >> 7) % 8188 + 1);
			d = {seed, ~seed[3:0]};
			if (ip)
				d[13:0] = {v[12:8], d[8], v[7:0]};
			else
				d[12:0] = v;
			wr(d);
			// model: the first four writes pop a register, the rest are data
			if (order.size() > 0)
				exp_ofs[order.pop_front()] = v;
			cmp_ofs();
			chk("port c ready", k >= 3, port_c_input_ready_o);
			chk("fifo1 ready", 1, fifo1_write_ready_o);
			chk("mem writes", mw + (k > 3 ? k - 3 : 0), mem_writes);
		end
		$display("test parallel ip=%0d done", ip);
	endtask
	// ****
	// clock, random core state, timeout
	// ****
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		seed = xs(seed);
		core <= seed[3:0];
		core_prev <= core;
		if (mem_write_o === 1'b1)
			mem_writes++;
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		seed = 32'd86242;
		{reset_n_i, start_i, fall_through_i, write_i} = 4'h0;
		flag_sel_i = 3'h7;
		write_data_i = 36'h0;
		core = 4'h0;
		core_prev = 4'h0;
		{bad_count, checks, cycles, mem_writes} = {4{32'd0}};
		repeat (8) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (16) @(posedge ref_clk_i);
		for (int p = 0; p < 2; p++)
			parallel_test(p[0]);
		foreach (presets[i]) begin
			setup(presets[i], i[0]);
			exp_ofs = '{4{preset_val(presets[i])}};
			cmp_ofs();
			chk("flags", {~core_prev[3], ~core_prev[1], ~core_prev[2],
				~core_prev[0]}, flags);
		end
		$display("test presets done");
		setup(3'h2, 1'b0);
		chk("serial mode", 1, serial_load_mode_o);
		chk("interspersed_parity_mode", 0, interspersed_parity_mode_o);
		$display("test serial done");
		final_report();
	end
endmodule
